//--- include/ptu_pkg.sv
package ptu_pkg;

    // bus and counter widths
    localparam int unsigned PTU_ADDR_W    = 12;
    localparam int unsigned PTU_DATA_W    = 32;
    localparam int unsigned PTU_TICK_W    = 20;
    localparam int unsigned PTU_ELAPSED_W = 12;
    localparam int unsigned PTU_DIV_W     = 4;

    // master clock prescale: one tick enable every sixteen clocks
    localparam int unsigned          PTU_DIV_RATIO = 16;
    localparam logic [PTU_DIV_W-1:0] PTU_DIV_LAST  = 4'hf;

    // register byte offsets
    localparam logic [PTU_ADDR_W-1:0] PTU_MODE_OFS   = 12'h000;
    localparam logic [PTU_ADDR_W-1:0] PTU_STATUS_OFS = 12'h004;
    localparam logic [PTU_ADDR_W-1:0] PTU_ACK_OFS    = 12'h008;
    localparam logic [PTU_ADDR_W-1:0] PTU_SNAP_OFS   = 12'h00c;

    // field positions
    localparam int unsigned PTU_MODE_LIMIT_LSB    = 0;
    localparam int unsigned PTU_MODE_TIMER_ON_BIT = 24;
    localparam int unsigned PTU_MODE_IRQ_ON_BIT   = 25;
    localparam int unsigned PTU_STATUS_FLAG_BIT   = 0;
    localparam int unsigned PTU_VIEW_TICK_LSB     = 0;
    localparam int unsigned PTU_VIEW_ELAPSED_LSB  = 20;

    // reset values
    localparam logic [PTU_DATA_W-1:0] PTU_MODE_RESET = 32'h000f_ffff;
    localparam logic [PTU_DATA_W-1:0] PTU_ZERO_WORD  = 32'h0000_0000;

    // decoded register select
    typedef enum logic [2:0] {
        PTU_REG_MODE,
        PTU_REG_STATUS,
        PTU_REG_ACK,
        PTU_REG_SNAP,
        PTU_REG_NONE
    } ptu_reg_e;

endpackage

//--- include/ptu_reg_if.sv
`timescale 1ns/1ps
interface ptu_reg_if;
    import ptu_pkg::*;

    logic                  mode_wr;     // one-cycle write strobe to mode register
    logic [PTU_DATA_W-1:0] wdata;       // write data for the mode register
    logic                  ack_rd;      // one-cycle acknowledging-read strobe
    logic [PTU_DATA_W-1:0] mode_val;    // mode register readback
    logic [PTU_DATA_W-1:0] status_val;  // status register readback
    logic [PTU_DATA_W-1:0] count_val;   // packed counter view

    modport bus (
        output mode_wr,
        output wdata,
        output ack_rd,
        input  mode_val,
        input  status_val,
        input  count_val
    );

    modport core (
        input  mode_wr,
        input  wdata,
        input  ack_rd,
        output mode_val,
        output status_val,
        output count_val
    );
endinterface

//--- rtl/ptu_apb_slave.sv
`timescale 1ns/1ps
module ptu_apb_slave
    import ptu_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [PTU_ADDR_W-1:0] paddr_i,
    input  wire logic [PTU_DATA_W-1:0] pwdata_i,
    output logic      [PTU_DATA_W-1:0] prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    ptu_reg_if.bus                     regs
);

    typedef struct packed {
        logic [PTU_DATA_W-1:0] rdata;
        logic                  slverr;
    } ptu_apb_s;

    ptu_apb_s s_q;
    ptu_apb_s s_d;
    logic     setup;
    logic     access;

    // word decode; the two low address bits are ignored
    function automatic ptu_reg_e ptu_decode(input logic [PTU_ADDR_W-1:0] addr);
        logic [PTU_ADDR_W-1:0] word;
        word = {addr[PTU_ADDR_W-1:2], 2'b00};
        if (word == PTU_MODE_OFS) begin
            return PTU_REG_MODE;
        end else if (word == PTU_STATUS_OFS) begin
            return PTU_REG_STATUS;
        end else if (word == PTU_ACK_OFS) begin
            return PTU_REG_ACK;
        end else if (word == PTU_SNAP_OFS) begin
            return PTU_REG_SNAP;
        end
        return PTU_REG_NONE;
    endfunction

    assign setup  = psel_i && !penable_i;
    assign access = psel_i && penable_i;

    // zero wait states: every access phase completes in its first cycle
    assign pready_o  = 1'b1;
    assign prdata_o  = s_q.rdata;
    assign pslverr_o = s_q.slverr;

    // strobes: the write lands at the completing edge, the acknowledge at
    // the setup edge, so the value captured and the clear see the same state
    assign regs.wdata   = pwdata_i;
    assign regs.mode_wr = access && pwrite_i && (ptu_decode(paddr_i) == PTU_REG_MODE);
    assign regs.ack_rd  = setup && !pwrite_i && (ptu_decode(paddr_i) == PTU_REG_ACK);

    // read data and error are captured during setup, held through access
    always_comb begin
        s_d = s_q;
        if (setup) begin
            s_d.slverr = (ptu_decode(paddr_i) == PTU_REG_NONE);
            s_d.rdata  = PTU_ZERO_WORD;
            if (!pwrite_i) begin
                unique case (ptu_decode(paddr_i))
                    PTU_REG_MODE:   s_d.rdata = regs.mode_val;
                    PTU_REG_STATUS: s_d.rdata = regs.status_val;
                    PTU_REG_ACK:    s_d.rdata = regs.count_val;
                    PTU_REG_SNAP:   s_d.rdata = regs.count_val;
                    PTU_REG_NONE:   s_d.rdata = PTU_ZERO_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule

//--- rtl/ptu_timer.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// Notes on behaviour
// - two counters: 20-bit tick count and 12-bit elapsed interval count
// - counters advance only on the master clock divided by sixteen enable
// - tick count runs 0 to limit, then wraps and bumps elapsed count
// - one interval lasts limit plus one divided ticks
// - wrap sets the reached flag; irq only while bit 25 is set
// - writing the limit neither resets nor restarts either counter
// - read at 0x08 returns counters, clears elapsed count and flag
// - read at 0x0c returns counters with no side effect
// - enable bit 24 acts only at tick count zero; stop after wrap
// - after reset timer disabled; mode register resets to 0x000f_ffff
// - both counters freeze while the core is in debug state
// - views: elapsed count in bits 31..20, tick count in 19..0
// - status at 0x04 shows reached flag in bit 0
// - mode: limit in low 20 bits, enable 24, irq enable 25
module ptu_timer
    import ptu_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  dbg_halt_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [PTU_ADDR_W-1:0] paddr_i,
    input  wire logic [PTU_DATA_W-1:0] pwdata_i,
    output logic      [PTU_DATA_W-1:0] prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    output logic                       irq_o
);

    typedef struct packed {
        logic [PTU_DIV_W-1:0]     div;
        logic [PTU_TICK_W-1:0]    interval_limit;
        logic                     tick_timer_on;
        logic                     tick_irq_on;
        logic [PTU_TICK_W-1:0]    tick_count;
        logic [PTU_ELAPSED_W-1:0] elapsed_interval_count;
        logic                     interval_reached_flag;
        logic                     irq;
    } ptu_state_s;

    ptu_state_s s_q;
    ptu_state_s s_d;
    logic       tick_en;
    logic       advance;
    logic       wrap;

    ptu_reg_if regs ();

    ptu_apb_slave u_apb (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .prdata_o  (prdata_o),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .regs      (regs.bus)
    );

    // both read views share one packing
    function automatic logic [PTU_DATA_W-1:0] ptu_pack_count(input ptu_state_s s);
        logic [PTU_DATA_W-1:0] w;
        w = PTU_ZERO_WORD;
        w[PTU_VIEW_ELAPSED_LSB +: PTU_ELAPSED_W] = s.elapsed_interval_count;
        w[PTU_VIEW_TICK_LSB +: PTU_TICK_W]       = s.tick_count;
        return w;
    endfunction

    // mode readback; reserved bits read as zero
    always_comb begin
        regs.mode_val = PTU_ZERO_WORD;
        regs.mode_val[PTU_MODE_LIMIT_LSB +: PTU_TICK_W] = s_q.interval_limit;
        regs.mode_val[PTU_MODE_TIMER_ON_BIT]            = s_q.tick_timer_on;
        regs.mode_val[PTU_MODE_IRQ_ON_BIT]              = s_q.tick_irq_on;
    end

    // status and counter views
    always_comb begin
        regs.status_val = PTU_ZERO_WORD;
        regs.status_val[PTU_STATUS_FLAG_BIT] = s_q.interval_reached_flag;
        regs.count_val  = ptu_pack_count(s_q);
    end

    // prescaler and debug freeze: the divider stops too, so a halt
    // does not slip a partial tick period
    assign tick_en = !dbg_halt_i && (s_q.div == PTU_DIV_LAST);

    // a cleared enable only stops the counter once it sits at zero, so a
    // running interval always finishes
    assign advance = tick_en && ((s_q.tick_count != '0) || s_q.tick_timer_on);
    assign wrap    = advance && (s_q.tick_count == s_q.interval_limit);

    // next state
    always_comb begin
        s_d = s_q;
        if (!dbg_halt_i) begin
            s_d.div = s_q.div + 4'h1;
        end
        // limit write leaves counters alone; a limit below the current
        // count runs the counter past 2^20 wrap before matching again
        if (regs.mode_wr) begin
            s_d.interval_limit = regs.wdata[PTU_MODE_LIMIT_LSB +: PTU_TICK_W];
            s_d.tick_timer_on  = regs.wdata[PTU_MODE_TIMER_ON_BIT];
            s_d.tick_irq_on    = regs.wdata[PTU_MODE_IRQ_ON_BIT];
        end
        // acknowledge first, so a wrap in the same cycle still counts
        if (regs.ack_rd) begin
            s_d.elapsed_interval_count = '0;
            s_d.interval_reached_flag  = 1'b0;
        end
        if (advance) begin
            if (wrap) begin
                s_d.tick_count             = '0;
                s_d.elapsed_interval_count = s_d.elapsed_interval_count + 12'h001;
                s_d.interval_reached_flag  = 1'b1;
            end else begin
                s_d.tick_count = s_q.tick_count + 20'h00001;
            end
        end
        s_d.irq = s_d.interval_reached_flag && s_d.tick_irq_on;
    end

    // reset value of the mode fields comes from the mode reset word
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q                        <= '0;
            s_q.interval_limit         <= PTU_MODE_RESET[PTU_MODE_LIMIT_LSB +: PTU_TICK_W];
            s_q.tick_timer_on          <= PTU_MODE_RESET[PTU_MODE_TIMER_ON_BIT];
            s_q.tick_irq_on            <= PTU_MODE_RESET[PTU_MODE_IRQ_ON_BIT];
        end else begin
            s_q <= s_d;
        end
    end

    assign irq_o = s_q.irq;

endmodule

//--- dv/ptu_timer_chk.sv
`timescale 1ns/1ps
module ptu_timer_chk
    import ptu_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  sys_rst_i,
    input  wire logic                  dbg_halt_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [PTU_ADDR_W-1:0] paddr_i,
    input  wire logic [PTU_DATA_W-1:0] pwdata_i,
    input  wire logic [PTU_DATA_W-1:0] prdata_o,
    input  wire logic                  pready_o,
    input  wire logic                  pslverr_o,
    input  wire logic                  irq_o
);
    logic ien_q;
    logic setup;

    // shadow of the irq enable, taken where the write lands
    assign setup = psel_i && !penable_i;
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ien_q <= 1'b0;
        end else if (psel_i && penable_i && pwrite_i && paddr_i[11:2] == 10'h000) begin
            ien_q <= pwdata_i[25];
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_ready_always: assert property (pready_o) else $error("pready low");
    a_err_unmapped: assert property (setup && paddr_i[11:4] != 8'h00
        |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && paddr_i[11:4] == 8'h00 |=> !pslverr_o)
        else $error("mapped access refused");
    a_rdata_stands: assert property (psel_i && penable_i |=> $stable(prdata_o))
        else $error("read data moved before next setup");
    a_status_pad: assert property (setup && !pwrite_i && paddr_i[11:2] == 10'h001
        |=> prdata_o[31:1] == 31'h0) else $error("status upper bits set");
    a_mode_reserved: assert property (setup && !pwrite_i && paddr_i[11:2] == 10'h000
        |=> prdata_o[31:26] == 6'h0 && prdata_o[23:20] == 4'h0)
        else $error("reserved mode bits read back");
    a_irq_gated: assert property (irq_o |-> ien_q) else $error("irq without enable");
    a_irq_mask_now: assert property (psel_i && penable_i && pwrite_i
        && paddr_i[11:2] == 10'h000 && !pwdata_i[25] |=> !irq_o)
        else $error("irq survived masking");
    a_halt_frozen: assert property ($past(dbg_halt_i) && !$past(psel_i)
        |-> $stable(irq_o)) else $error("irq moved during halt");
endmodule

bind ptu_timer ptu_timer_chk ptu_timer_chk_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .dbg_halt_i(dbg_halt_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o)
);

//--- dv/ptu_timer_tb_top.sv
`timescale 1ns/1ps
module ptu_timer_tb_top
    import ptu_pkg::*;
;
    logic                  clk_sys_i  = 1'b0;
    logic                  sys_rst_i  = 1'b1;
    logic                  dbg_halt_i = 1'b0;
    logic                  psel_i     = 1'b0;
    logic                  penable_i  = 1'b0;
    logic                  pwrite_i   = 1'b0;
    logic [PTU_ADDR_W-1:0] paddr_i    = 12'h000;
    logic [PTU_DATA_W-1:0] pwdata_i   = 32'h0000_0000;
    logic [PTU_DATA_W-1:0] prdata_o;
    logic                  pready_o;
    logic                  pslverr_o;
    logic                  irq_o;
    int                    miscompares = 0;
    int                    tests_run   = 0;
    int                    seed        = 67;
    logic [PTU_DATA_W-1:0] r, a, lim, md;
    logic                  e;
    realtime               t1;

    always #20 clk_sys_i = ~clk_sys_i;

    ptu_timer ptu_timer_i (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .dbg_halt_i(dbg_halt_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .irq_o(irq_o)
    );

    // expected views: reserved mode bits read zero, counters packed high/low
    function automatic logic [31:0] mexp(input logic [31:0] d);
        return d & 32'h030f_ffff;
    endfunction
    function automatic logic [31:0] view(input logic [11:0] el, input logic [19:0] tk);
        return {el, tk};
    endfunction

    task automatic conclude();
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; data and error taken at the edge pready is seen
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= ad;
        pwdata_i  <= d;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        r = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        if (pready_o !== 1'b1) begin
            miscompares++;
            conclude();
        end
    endtask

    // bounded wait for an irq level; a long limit guards against a hang
    task automatic wirq(input logic lv);
        int n;
        n = 0;
        while (irq_o !== lv && n < 40000) begin
            @(posedge clk_sys_i);
            n++;
        end
        if (irq_o !== lv) begin
            miscompares++;
            conclude();
        end
    endtask

    initial begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        // reset values and the refused unmapped word
        apb(1'b0, PTU_MODE_OFS, 32'h0);
        chk(r, PTU_MODE_RESET);
        apb(1'b0, PTU_STATUS_OFS, 32'h0);
        chk(r, PTU_ZERO_WORD);
        apb(1'b0, PTU_ACK_OFS, 32'h0);
        chk(r, view(12'h0, 20'h0));
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk(r, view(12'h0, 20'h0));
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, e}, 32'h1);
        // random short limit, random junk in the reserved bits
        lim = 32'h2 + ($random(seed) & 32'h3);
        md = ($random(seed) & 32'hfcf0_0000) | 32'h0300_0000 | lim;
        apb(1'b1, PTU_MODE_OFS, md);
        apb(1'b0, PTU_MODE_OFS, 32'h0);
        chk(r, mexp(md));
        wirq(1'b1);
        t1 = $realtime;
        apb(1'b0, PTU_ACK_OFS, 32'h0);
        chk({20'h0, r[31:20]}, 32'h1);
        apb(1'b0, PTU_STATUS_OFS, 32'h0);
        chk(r, PTU_ZERO_WORD);
        wirq(1'b0);
        wirq(1'b1);
        chk(int'(($realtime - t1) / 40.0), (lim + 32'h1) * 32'h10);
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk({20'h0, r[31:20]}, 32'h1);
        apb(1'b0, PTU_STATUS_OFS, 32'h0);
        chk(r, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        // new limit mid-interval keeps the counters running
        apb(1'b1, PTU_MODE_OFS, 32'h0300_0000 | (lim + 32'h1));
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk({20'h0, r[31:20]}, 32'h1);
        apb(1'b1, PTU_MODE_OFS, 32'h0100_0000 | (lim + 32'h1));
        @(posedge clk_sys_i);
        chk({31'h0, irq_o}, 32'h0);
        // a write to the acknowledge word is no acknowledge
        apb(1'b1, PTU_ACK_OFS, 32'hffff_ffff);
        apb(1'b0, PTU_STATUS_OFS, 32'h0);
        chk(r, 32'h1);
        // disable: finishes the interval, then parks at zero
        apb(1'b1, PTU_MODE_OFS, lim + 32'h1);
        repeat (200) @(posedge clk_sys_i);
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk({12'h0, r[19:0]}, 32'h0);
        apb(1'b0, PTU_ACK_OFS, 32'h0);
        repeat (200) @(posedge clk_sys_i);
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk(r, view(12'h0, 20'h0));
        // debug halt freezes a running count; irq armed so a slip shows
        apb(1'b1, PTU_MODE_OFS, 32'h0300_0000 | lim);
        repeat (20) @(posedge clk_sys_i);
        dbg_halt_i <= 1'b1;
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        a = r;
        repeat (100) @(posedge clk_sys_i);
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk(r, a);
        chk({31'h0, irq_o}, 32'h0);
        // release: counting resumes and ends exactly one interval
        dbg_halt_i <= 1'b0;
        wirq(1'b1);
        apb(1'b0, PTU_SNAP_OFS, 32'h0);
        chk({20'h0, r[31:20]}, 32'h1);
        conclude();
    end
endmodule
